/* File: rtl/prw_pkg.sv */
// constants and types of the power, reset and watchdog sequencer
package prw_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned POR_TIME_NS   = 2_500_000;
  localparam int unsigned POR_CYC       = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RC_DIV        = 4;
  localparam logic [15:0] POR_TICKS     = 16'((POR_CYC + RC_DIV - 1) / RC_DIV);
  localparam int unsigned DIV16         = 16;
  localparam int unsigned WIN_PROC_CYC  = 60;
  localparam int unsigned CLK_PER_PROC  = 2;
  localparam logic [7:0]  WIN_CYC       = 8'(WIN_PROC_CYC * CLK_PER_PROC);
  // watchdog taps in rc ticks; plain defaults
  localparam logic [15:0] WDT_TAP0      = 16'h0400;
  localparam logic [15:0] WDT_TAP1      = 16'h0800;
  localparam logic [15:0] WDT_TAP2      = 16'h1000;
  localparam logic [15:0] WDT_TAP3      = 16'h2000;

  // ****************************************************
  // register map: indices, byte address is index times four
  // ****************************************************
  localparam logic [7:0]  IDX_SRC       = 8'h0b;
  localparam logic [7:0]  IDX_WDM       = 8'h0f;
  localparam logic [7:0]  IDX_STAT      = 8'h10;
  localparam logic [7:0]  IDX_CMD       = 8'h11;
  localparam int unsigned SRC_DIV16_BIT = 0;
  localparam int unsigned SRC_PORB_BIT  = 5;
  localparam int unsigned WDM_HALT_BIT  = 2;
  localparam int unsigned WDM_STOP_BIT  = 3;
  localparam logic [7:0]  WDM_USED_MASK = 8'h0f;
  localparam logic [7:0]  SRC_RST       = 8'h00;
  localparam logic [7:0]  WDM_RST       = 8'h00;

  // ****************************************************
  // opcodes and restart address
  // ****************************************************
  localparam logic [7:0]  OPC_NOP       = 8'hff;
  localparam logic [7:0]  OPC_STOP      = 8'h6f;
  localparam logic [7:0]  OPC_HALT      = 8'h7f;
  localparam logic [7:0]  OPC_WDT       = 8'h5f;
  localparam logic [15:0] RESTART_ADDR  = 16'h000c;

  typedef enum logic [1:0] {
    PRW_RST  = 2'b00,
    PRW_RUN  = 2'b01,
    PRW_HALT = 2'b10,
    PRW_STOP = 2'b11
  } prw_state_t;

  function automatic logic prw_is_reg(input logic [31:0] a, input logic [7:0] idx);
    return a == {22'h0, idx, 2'b00};
  endfunction

endpackage

/* File: rtl/prw_div.sv */
// free running divider giving a one-cycle enable pulse
`timescale 1ns/100ps
module prw_div #(
  parameter int unsigned DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      pulse_o
);
  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= (cnt_q == LAST);
      cnt_q   <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

/* File: rtl/prw_wdog.sv */
// retriggerable watchdog one-shot counting rc oscillator ticks
`timescale 1ns/100ps
module prw_wdog
  import prw_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       clear_i,
  input  wire logic       kick_i,
  input  wire logic       run_i,
  input  wire logic [1:0] tap_i,
  output logic            running_o,
  output logic            timeout_o
);
  logic [15:0] cnt_q;
  logic [15:0] limit;

  always_comb begin
    case (tap_i)
      2'b00:   limit = WDT_TAP0;
      2'b01:   limit = WDT_TAP1;
      2'b10:   limit = WDT_TAP2;
      default: limit = WDT_TAP3;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      running_o <= 1'b0;
      timeout_o <= 1'b0;
      cnt_q     <= 16'h0000;
    end else begin
      timeout_o <= 1'b0;
      if (kick_i) begin
        running_o <= 1'b1;
        cnt_q     <= 16'h0000;
      end else if (running_o && run_i && tick_i) begin
        if (cnt_q + 16'h0001 >= limit) begin
          timeout_o <= 1'b1;
          running_o <= 1'b0;
          cnt_q     <= 16'h0000;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule

/* File: rtl/prw_top.sv */
// power, reset and watchdog sequencer with ahb-lite register slave
`timescale 1ns/100ps
module prw_top
  import prw_pkg::*;
#(
  parameter logic [15:0] POR_TICKS_P = POR_TICKS
) (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic        HWRITE_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        PWR_GOOD_I,
  input  wire logic        EXT_RST_I,
  input  wire logic        STOP_WAKE_I,
  input  wire logic        IRQ_SERVICE_I,
  output logic             CPU_RST_O,
  output logic             CPU_CLK_EN_O,
  output logic             TMR_CLK_EN_O,
  output logic             XTAL_EN_O,
  output logic      [1:0]  MODE_O,
  output logic             RESTART_O,
  output logic      [15:0] RESTART_ADDR_O,
  output logic             FLAG_UPD_O
);

  // ****************************************************
  // clock enables
  // ****************************************************
  logic rc_tick;
  logic d16_tick;

  prw_div #(.DIV(RC_DIV)) u_rc (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .pulse_o (rc_tick)
  );

  prw_div #(.DIV(DIV16)) u_d16 (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .pulse_o (d16_tick)
  );

  // ****************************************************
  // ahb-lite slave
  // ****************************************************
  logic        take;
  logic        wr_q;
  logic [31:0] addr_q;
  logic [31:0] rd_d;
  logic [7:0]  src_q;
  logic [7:0]  wdm_q;
  logic [5:0]  stat;
  prw_state_t  st_q;
  prw_state_t  st_d;
  logic        rst_q;
  logic        wdt_run;
  logic        wdm_open;
  logic        nop_q;

  assign take = HSEL_I && HTRANS_I[1] && HREADY_I && (HSIZE_I == 3'b010);
  assign stat = {nop_q, wdm_open, wdt_run, st_q, rst_q};

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wr_q   <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else begin
      wr_q <= take && HWRITE_I;
      if (take) begin
        addr_q <= HADDR_I;
      end
    end
  end

  always_comb begin
    if (prw_is_reg(HADDR_I, IDX_SRC)) begin
      rd_d = {24'h00_0000, src_q};
    end else if (prw_is_reg(HADDR_I, IDX_STAT)) begin
      rd_d = {26'h000_0000, stat};
    end else begin
      // mode register and command read as zero
      rd_d = 32'h0000_0000;
    end
  end

  // zero wait states; unmapped addresses answer okay, reads give zero
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HRDATA_O    <= (take && !HWRITE_I) ? rd_d : 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  logic       src_wr;
  logic       wdm_wr;
  logic       cmd_wr;
  logic [7:0] opc;

  assign src_wr = wr_q && prw_is_reg(addr_q, IDX_SRC);
  assign wdm_wr = wr_q && prw_is_reg(addr_q, IDX_WDM);
  assign cmd_wr = wr_q && prw_is_reg(addr_q, IDX_CMD) && (st_q == PRW_RUN);
  assign opc    = HWDATA_I[7:0];

  // ****************************************************
  // reset sources
  // ****************************************************
  logic        pg_q;
  logic        pg_rise;
  logic        wdt_to;
  logic        wake;
  logic        por_trig;
  logic        byp;
  logic        kick;
  logic [15:0] por_cnt_q;

  assign pg_rise = PWR_GOOD_I && !pg_q;
  assign wake    = STOP_WAKE_I && (st_q == PRW_STOP);
  assign por_trig = pg_rise || wdt_to || (wake && src_q[SRC_PORB_BIT]);
  assign byp      = wake && !src_q[SRC_PORB_BIT] && PWR_GOOD_I && !EXT_RST_I && !wdt_to;
  assign kick     = cmd_wr && (opc == OPC_WDT);

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= PWR_GOOD_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      por_cnt_q <= POR_TICKS_P;
    end else if (!PWR_GOOD_I || por_trig) begin
      por_cnt_q <= POR_TICKS_P;
    end else if (rc_tick && por_cnt_q != 16'h0000) begin
      por_cnt_q <= por_cnt_q - 16'h0001;
    end
  end

  // ****************************************************
  // power state sequencer
  // ****************************************************
  always_comb begin
    st_d = st_q;
    if (!PWR_GOOD_I || por_trig || EXT_RST_I) begin
      st_d = PRW_RST;
    end else begin
      case (st_q)
        PRW_RST: begin
          if (por_cnt_q == 16'h0000) begin
            st_d = PRW_RUN;
          end
        end
        PRW_RUN: begin
          if (cmd_wr && opc == OPC_HALT) begin
            st_d = PRW_HALT;
          end else if (cmd_wr && opc == OPC_STOP) begin
            st_d = PRW_STOP;
          end
        end
        PRW_HALT: begin
          if (IRQ_SERVICE_I) begin
            st_d = PRW_RUN;
          end
        end
        PRW_STOP: begin
          if (byp) begin
            st_d = PRW_RUN;
          end
        end
        default: st_d = PRW_RST;
      endcase
    end
  end

  logic sclk_en;
  assign sclk_en = src_q[SRC_DIV16_BIT] ? d16_tick : 1'b1;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st_q         <= PRW_RST;
      rst_q        <= 1'b1;
      CPU_RST_O    <= 1'b1;
      CPU_CLK_EN_O <= 1'b0;
      TMR_CLK_EN_O <= 1'b0;
      XTAL_EN_O    <= 1'b1;
      MODE_O       <= PRW_RST;
      RESTART_O    <= 1'b0;
    end else begin
      st_q         <= st_d;
      rst_q        <= (st_d == PRW_RST);
      CPU_RST_O    <= (st_d == PRW_RST);
      CPU_CLK_EN_O <= (st_d == PRW_RUN) && sclk_en;
      TMR_CLK_EN_O <= (st_d == PRW_RUN || st_d == PRW_HALT) && sclk_en;
      XTAL_EN_O    <= (st_d != PRW_STOP);
      MODE_O       <= st_d;
      RESTART_O    <= (st_q == PRW_RST && st_d == PRW_RUN) || (st_q != PRW_RST && byp);
    end
  end

  always_ff @(posedge CLK_I) begin
    RESTART_ADDR_O <= RESTART_ADDR;
  end

  // ****************************************************
  // registers
  // ****************************************************
  logic [7:0] win_q;
  assign wdm_open = (win_q < WIN_CYC) && (st_q != PRW_RST);

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      src_q <= SRC_RST;
    end else begin
      if (src_wr) begin
        src_q <= HWDATA_I[7:0];
      end
      if (wake) begin
        src_q[SRC_DIV16_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || st_q == PRW_RST || byp) begin
      win_q <= 8'h00;
    end else if (win_q < WIN_CYC && st_q != PRW_STOP) begin
      win_q <= win_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wdm_q <= WDM_RST;
    end else if (wdm_wr && wdm_open) begin
      wdm_q <= HWDATA_I[7:0] & WDM_USED_MASK;
    end
  end

  // last command was a pipeline flush
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      nop_q      <= 1'b0;
      FLAG_UPD_O <= 1'b0;
    end else begin
      if (cmd_wr) begin
        nop_q <= (opc == OPC_NOP);
      end
      FLAG_UPD_O <= kick;
    end
  end

  // ****************************************************
  // watchdog
  // ****************************************************
  logic wdt_en;
  assign wdt_en = (st_q == PRW_RUN) || (st_q == PRW_HALT && wdm_q[WDM_HALT_BIT])
               || (st_q == PRW_STOP && wdm_q[WDM_STOP_BIT]);

  prw_wdog u_wdog (
    .clk_i     (CLK_I),
    .rst_i     (SYS_RST_I),
    .tick_i    (rc_tick),
    .clear_i   (st_q == PRW_RST),
    .kick_i    (kick),
    .run_i     (wdt_en),
    .tap_i     (wdm_q[1:0]),
    .running_o (wdt_run),
    .timeout_o (wdt_to)
  );

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_POR_HOLD: assert property (st_q == PRW_RST && por_cnt_q != 16'h0000
    |=> CPU_RST_O)
    else $error("cpu reset released while one-shot running");
  AST_POR_LOAD: assert property (por_trig |=> por_cnt_q == POR_TICKS_P)
    else $error("one-shot not reloaded by trigger");
  AST_POR_MIN: assert property ($fell(CPU_RST_O) |-> $past(por_cnt_q) == 16'h0000)
    else $error("reset released before one-shot expiry");
  AST_BYPASS: assert property (byp |=> !CPU_RST_O && RESTART_O && MODE_O == PRW_RUN)
    else $error("bypass recovery did not restart at once");
  AST_HALT_CLK: assert property (MODE_O == PRW_HALT |-> !CPU_CLK_EN_O && XTAL_EN_O)
    else $error("clock gating wrong in halt");
  AST_HALT_EXIT: assert property (st_q == PRW_HALT && !IRQ_SERVICE_I
    && PWR_GOOD_I && !EXT_RST_I && !por_trig |=> st_q == PRW_HALT)
    else $error("halt left without a serviced interrupt");
  AST_STOP_CLK: assert property (MODE_O == PRW_STOP
    |-> !CPU_CLK_EN_O && !XTAL_EN_O && !TMR_CLK_EN_O)
    else $error("clocks running in stop");
  AST_DIV_CLR: assert property (wake |=> !src_q[SRC_DIV16_BIT])
    else $error("divide select not cleared on recovery");
  AST_WDM_LOCK: assert property (wdm_wr && !wdm_open |=> $stable(wdm_q))
    else $error("mode register changed after lock");
  AST_WDM_READ: assert property (take && !HWRITE_I && prw_is_reg(HADDR_I, IDX_WDM)
    |=> HRDATA_O == 32'h0000_0000)
    else $error("mode register readable");
  AST_WDT_RST: assert property (wdt_to |=> CPU_RST_O ##1 CPU_RST_O)
    else $error("watchdog timeout did not reset cpu");

  COV_HALT_WAKE: cover property (st_q == PRW_HALT ##1 st_q == PRW_RUN);
  COV_STOP_BYP: cover property (byp);
  COV_WDT_TO: cover property (wdt_to);
endmodule

/* File: test/tb_power_reset_watchdog.sv */
// self-checking bench of the power, reset and watchdog sequencer
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module tb_power_reset_watchdog
  import prw_pkg::*;
;
  // ****************************************************
  // settings and signals
  // ****************************************************
  // short one-shot keeps the run brief
  localparam logic [15:0] POR_SIM = 16'h0014;
  localparam int          POR_MIN = (int'(POR_SIM) - 1) * RC_DIV + 1;
  localparam int          POR_MAX = int'(POR_SIM) * RC_DIV + 10;
  localparam int          WD_CYC  = int'(WDT_TAP0) * RC_DIV;
  localparam int          WD1_CYC = int'(WDT_TAP1) * RC_DIV;

  logic        clk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        pwr_good;
  logic        ext_rst;
  logic        stop_wake;
  logic        irq_srv;
  logic        cpu_rst;
  logic        cpu_clk_en;
  logic        tmr_clk_en;
  logic        xtal_en;
  logic [1:0]  mode;
  logic        restart;
  logic [15:0] restart_addr;
  logic        flag_upd;
  logic [31:0] rd;
  logic [31:0] a;
  int          fails;
  int          checks_done;
  int          seed;
  int          n;
  int          c;
  int          t;

  prw_top #(
    .POR_TICKS_P (POR_SIM)
  ) uut (
    .CLK_I          (clk),
    .SYS_RST_I      (sys_rst),
    .HSEL_I         (hsel),
    .HADDR_I        (haddr),
    .HWRITE_I       (hwrite),
    .HTRANS_I       (htrans),
    .HSIZE_I        (hsize),
    .HWDATA_I       (hwdata),
    .HREADY_I       (hreadyout),
    .HRDATA_O       (hrdata),
    .HREADYOUT_O    (hreadyout),
    .HRESP_O        (hresp),
    .PWR_GOOD_I     (pwr_good),
    .EXT_RST_I      (ext_rst),
    .STOP_WAKE_I    (stop_wake),
    .IRQ_SERVICE_I  (irq_srv),
    .CPU_RST_O      (cpu_rst),
    .CPU_CLK_EN_O   (cpu_clk_en),
    .TMR_CLK_EN_O   (tmr_clk_en),
    .XTAL_EN_O      (xtal_en),
    .MODE_O         (mode),
    .RESTART_O      (restart),
    .RESTART_ADDR_O (restart_addr),
    .FLAG_UPD_O     (flag_upd)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic end_sim();
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [31:0] ra(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  function automatic logic [1:0] cur(input int s);
    case (s)
      0: return {1'b0, cpu_rst};
      1: return mode;
      default: return {1'b0, restart};
    endcase
  endfunction

  // bounded wait on a design output seen at the rising edge
  task automatic waitv(input int s, input logic [1:0] v, input int lim, output int k);
    k = 0;
    while (cur(s) !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (cur(s) !== v) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      end_sim();
    end
  endtask

  // single word transfer; read data taken at the closing edge
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= ad;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [31:0] ad, input logic [31:0] ex);
    logic [31:0] r;
    ahb(1'b0, ad, 32'h0, r);
    `CHK(nm, ex, r)
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic cmd(input logic [7:0] op);
    ahb(1'b1, ra(IDX_CMD), {24'h0, op}, rd);
  endtask

  task automatic sett(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic cnt_en(output int cc, output int tt);
    cc = 0;
    tt = 0;
    repeat (64) begin
      @(posedge clk);
      cc += int'(cpu_clk_en === 1'b1);
      tt += int'(tmr_clk_en === 1'b1);
    end
  endtask

  task automatic irq_pulse();
    @(posedge clk);
    irq_srv <= 1'b1;
    @(posedge clk);
    irq_srv <= 1'b0;
  endtask

  task automatic wake_pulse();
    @(posedge clk);
    stop_wake <= 1'b1;
    @(posedge clk);
    stop_wake <= 1'b0;
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    seed = 16231;
    fails = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    {hsel, hwrite, pwr_good, ext_rst, stop_wake, irq_srv} = 6'h00;
    haddr = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    sett(1);
    `CHK("rst_held", 1'b1, cpu_rst)
    `CHK("xtal_rst", 1'b1, xtal_en)
    `CHK("rst_addr", RESTART_ADDR, restart_addr)
    @(posedge clk);
    pwr_good <= 1'b1;
    waitv(0, 2'b00, 400, n);
    `CHK("por_len", 1'b1, n >= POR_MIN && n <= POR_MAX)
    `CHK("mode_run", 2'b01, mode)
    ahb(1'b0, ra(IDX_STAT), 32'h0, rd);
    `CHK("win_open", 1'b1, rd[4])
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, ra(IDX_WDM), $random(seed), rd);
      rchk("wdm_read", ra(IDX_WDM), 32'h0);
    end
    // tap 0, stopped in halt and stop, locked from here on
    ahb(1'b1, ra(IDX_WDM), 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      a = 32'h0000_0100 | ({$random(seed)} & 32'h0000_0efc);
      ahb(1'b1, a, $random(seed), rd);
      rchk("unmapped", a, 32'h0);
    end
    cnt_en(c, t);
    `CHK("cpu_full", 64, c)
    `CHK("tmr_full", 64, t)
    ahb(1'b0, ra(IDX_STAT), 32'h0, rd);
    `CHK("win_shut", 1'b0, rd[4])
    ahb(1'b1, ra(IDX_WDM), 32'h0000_000c, rd);
    cmd(OPC_WDT);
    #1;
    `CHK("flag_on", 1'b1, flag_upd)
    sett(1);
    `CHK("flag_off", 1'b0, flag_upd)
    ahb(1'b0, ra(IDX_STAT), 32'h0, rd);
    `CHK("wd_run", 1'b1, rd[3])
    ahb(1'b1, ra(IDX_SRC), 32'h0000_0001, rd);
    rchk("src_rw", ra(IDX_SRC), 32'h0000_0001);
    cmd(OPC_NOP);
    cmd(OPC_HALT);
    sett(1);
    `CHK("halt_mode", 2'b10, mode)
    `CHK("halt_xtal", 1'b1, xtal_en)
    cnt_en(c, t);
    `CHK("halt_cpu", 0, c)
    `CHK("halt_tmr", 4, t)
    irq_pulse();
    waitv(1, 2'b01, 8, n);
    `CHK("halt_exit", 2'b01, mode)
    cnt_en(c, t);
    `CHK("cpu_div", 4, c)
    cmd(OPC_WDT);
    cmd(OPC_NOP);
    cmd(OPC_STOP);
    sett(1);
    `CHK("stop_mode", 2'b11, mode)
    `CHK("stop_xtal", 1'b0, xtal_en)
    `CHK("stop_cpu", 1'b0, cpu_clk_en)
    irq_pulse();
    // longer than tap 0: a watchdog left running in stop would fire
    sett(WD_CYC + 400);
    `CHK("stop_held", 2'b11, mode)
    `CHK("stop_norst", 1'b0, cpu_rst)
    wake_pulse();
    waitv(2, 2'b01, 8, n);
    `CHK("wake_mode", 2'b01, mode)
    `CHK("wake_norst", 1'b0, cpu_rst)
    `CHK("wake_addr", RESTART_ADDR, restart_addr)
    rchk("div_clear", ra(IDX_SRC), 32'h0000_0000);
    ahb(1'b1, ra(IDX_SRC), 32'h0000_0020, rd);
    cmd(OPC_NOP);
    cmd(OPC_STOP);
    wake_pulse();
    waitv(0, 2'b01, 8, n);
    `CHK("wake_rst", 1'b1, cpu_rst)
    waitv(0, 2'b00, 400, n);
    `CHK("wake_por", 1'b1, n >= POR_MIN - 4 && n <= POR_MAX)
    cmd(OPC_WDT);
    sett(WD_CYC - 1000);
    cmd(OPC_WDT);
    waitv(0, 2'b01, WD_CYC + 400, n);
    `CHK("wd_time", 1'b1, n >= WD_CYC - 16 && n <= WD_CYC + 16)
    waitv(0, 2'b00, 400, n);
    `CHK("wd_por", 1'b1, n >= POR_MIN - 4 && n <= POR_MAX)
    // window reopened by the watchdog reset: tap 1, kept running in stop
    ahb(1'b1, ra(IDX_WDM), 32'h0000_0009, rd);
    cmd(OPC_WDT);
    cmd(OPC_NOP);
    cmd(OPC_STOP);
    waitv(0, 2'b01, WD1_CYC + 400, n);
    `CHK("stop_wd", 1'b1, n >= WD1_CYC - 40 && n <= WD1_CYC + 16)
    waitv(0, 2'b00, 400, n);
    `CHK("stop_wd_por", 1'b1, n >= POR_MIN - 4 && n <= POR_MAX)
    @(posedge clk);
    ext_rst <= 1'b1;
    sett(2);
    `CHK("ext_rst", 1'b1, cpu_rst)
    `CHK("ext_mode", 2'b00, mode)
    end_sim();
  end
endmodule
